/* File: hdl/smk_security.sv */
// security-level controller with key-pair unlock
//
// Functional notes
// - Three levels; full access reads/writes everything, unsealed everything but key writes; sealed hides data and mfg is read-only.
// - Key values may only be rewritten at full access; otherwise unsealed equals full access.
// - Each unseal or full-access change needs its own two-key pair sent on the control port; sealing uses sealCmd.
// - Sealed flag is set while sealed and cleared after a correct unseal pair.
// - The full-access flag is cleared after a correct full-access pair.
// - Each key word is two bytes and lives in the stored data.
// - Stored keys change only at full access; other attempts are refused.
// - Control-port key words arrive byte-swapped versus the stored word.
// - A parameter store addressed by class and byte offset holds the settings.
// - Class and block select writes are ignored while sealed.
`timescale 1ns/100ps
module smk_security import smk_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// control command port
	input wire smk_ctl_s ctl,
	input wire logic sealCmd,
	// class and block select
	input wire logic classSelWr,
	input wire logic blockSelWr,
	input wire logic [7:0] selData,
	// parameter store access
	input wire logic accValid,
	input wire logic accWrite,
	input wire logic [7:0] accOffset,
	input wire logic [7:0] accWdata,
	output logic [7:0] accRdata,
	output logic accDenied,
	// status
	output logic sealedFlag,
	output logic full_access_flag,
	output logic [2:0] level,
	output logic [7:0] class_select,
	output logic [7:0] block_select
);
	smk_level_e level_reg, level_next;
	smk_kstate_e kstate_reg, kstate_next;
	logic [15:0] firstKey_reg;
	logic [7:0] classSel_reg;
	logic [7:0] blockSel_reg;
	logic sealedFlag_reg;
	logic fullFlag_reg;
	logic [15:0] uk0, uk1, fk0, fk1;
	smk_acc_s acc;

	wire isSealed = level_reg == SMK_SEALED;
	wire isFull = level_reg == SMK_FULL;
	wire [15:0] keyWord = smkSwap(ctl.data);
	wire unsealMatch = firstKey_reg == uk0 && keyWord == uk1;
	wire fullMatch = firstKey_reg == fk0 && keyWord == fk1;
	wire pairDone = ctl.valid && kstate_reg == SMK_KHALF;
	wire doUnseal = pairDone && isSealed && unsealMatch;
	wire doFull = pairDone && level_reg == SMK_UNSEALED && fullMatch;

	always_comb begin
		kstate_next = kstate_reg;
		level_next = level_reg;
		case (kstate_reg)
			SMK_KIDLE: begin
				if (ctl.valid)
					kstate_next = SMK_KHALF;
			end
			SMK_KHALF: begin
				// second write closes the pair either way
				if (ctl.valid)
					kstate_next = SMK_KIDLE;
			end
			default: kstate_next = SMK_KIDLE;
		endcase
		// level moves on an exact pair or on sealCmd
		if (doUnseal)
			level_next = SMK_UNSEALED;
		else if (doFull)
			level_next = SMK_FULL;
		else if (sealCmd)
			level_next = SMK_SEALED;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			level_reg <= SMK_RST_LEVEL;
			kstate_reg <= SMK_KIDLE;
			firstKey_reg <= 16'h0000;
		end else begin
			level_reg <= level_next;
			kstate_reg <= kstate_next;
			if (ctl.valid && kstate_reg == SMK_KIDLE)
				firstKey_reg <= keyWord;
		end
	end

	// flags follow the next level so a seal and a pair in one cycle never split them
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sealedFlag_reg <= 1'b1;
			fullFlag_reg <= 1'b1;
		end else begin
			sealedFlag_reg <= level_next == SMK_SEALED;
			fullFlag_reg <= level_next != SMK_FULL;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			classSel_reg <= 8'h00;
			blockSel_reg <= 8'h00;
		end else begin
			if (classSelWr && !isSealed)
				classSel_reg <= selData;
			if (blockSelWr && !isSealed)
				blockSel_reg <= selData;
		end
	end

	// sealed access always targets the mfg class
	assign acc = '{valid: accValid, write: accWrite,
		cls: isSealed ? SMK_CLASS_MFG : classSel_reg,
		offset: 8'(accOffset + {blockSel_reg[2:0], 5'h00}), wdata: accWdata};

	smk_key_store store (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.acc(acc),
		.dataAllowed(!isSealed),
		.mfgWriteAllowed(!isSealed),
		.keyWriteAllowed(isFull),
		.rdata(accRdata),
		.accDenied(accDenied),
		.unsealKey0(uk0),
		.unsealKey1(uk1),
		.fullKey0(fk0),
		.fullKey1(fk1)
	);

	assign sealedFlag = sealedFlag_reg;
	assign full_access_flag = fullFlag_reg;
	assign level = level_reg;
	assign class_select = classSel_reg;
	assign block_select = blockSel_reg;
endmodule

/* File: hdl/smk_pkg.sv */
// shared constants and types for the security-mode key unlock block
package smk_pkg;
	// security levels, one-hot
	typedef enum logic [2:0] {
		SMK_FULL = 3'h1,
		SMK_UNSEALED = 3'h2,
		SMK_SEALED = 3'h4
	} smk_level_e;

	// key-pair receiver states, one-hot
	typedef enum logic [1:0] {
		SMK_KIDLE = 2'h1,
		SMK_KHALF = 2'h2
	} smk_kstate_e;

	// one control-port write
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} smk_ctl_s;

	// parameter store access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] cls;
		logic [7:0] offset;
		logic [7:0] wdata;
	} smk_acc_s;

	localparam int SMK_STORE_DEPTH = 256;
	localparam logic [7:0] SMK_CLASS_MFG = 8'h3A;
	localparam logic [7:0] SMK_CLASS_SECURITY = 8'h70;
	// offsets of stored key words inside the security class
	localparam logic [7:0] SMK_OFS_UNSEAL0 = 8'h00;
	localparam logic [7:0] SMK_OFS_UNSEAL1 = 8'h02;
	localparam logic [7:0] SMK_OFS_FULL0 = 8'h04;
	localparam logic [7:0] SMK_OFS_FULL1 = 8'h06;
	// reset values of stored keys (arbitrary)
	localparam logic [15:0] SMK_RST_UNSEAL0 = 16'h1234;
	localparam logic [15:0] SMK_RST_UNSEAL1 = 16'h5678;
	localparam logic [15:0] SMK_RST_FULL0 = 16'h9ABC;
	localparam logic [15:0] SMK_RST_FULL1 = 16'hDEF0;
	localparam smk_level_e SMK_RST_LEVEL = SMK_SEALED;

	function automatic logic [15:0] smkSwap(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction
endpackage

/* File: hdl/smk_key_store.sv */
// byte-wide parameter store with key words and class-based gating
`timescale 1ns/100ps
module smk_key_store import smk_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// access
	input wire smk_acc_s acc,
	input wire logic dataAllowed,
	input wire logic mfgWriteAllowed,
	input wire logic keyWriteAllowed,
	// results
	output logic [7:0] rdata,
	output logic accDenied,
	output logic [15:0] unsealKey0,
	output logic [15:0] unsealKey1,
	output logic [15:0] fullKey0,
	output logic [15:0] fullKey1
);
	logic [7:0] mem [SMK_STORE_DEPTH];
	logic [7:0] keyByte_reg [8];
	logic [7:0] rdata_reg;
	logic denied_reg;

	wire isKey = acc.cls == SMK_CLASS_SECURITY && acc.offset < 8'h08;
	wire isMfg = acc.cls == SMK_CLASS_MFG;
	wire permit = acc.write ? (isKey ? keyWriteAllowed : (isMfg ? mfgWriteAllowed : dataAllowed))
		: (isMfg ? 1'b1 : dataAllowed);
	wire [7:0] memIdx = acc.offset ^ (isMfg ? 8'h80 : 8'h00);

	assign unsealKey0 = {keyByte_reg[0], keyByte_reg[1]};
	assign unsealKey1 = {keyByte_reg[2], keyByte_reg[3]};
	assign fullKey0 = {keyByte_reg[4], keyByte_reg[5]};
	assign fullKey1 = {keyByte_reg[6], keyByte_reg[7]};
	assign rdata = rdata_reg;
	assign accDenied = denied_reg;

	always_ff @(posedge ref_clk) begin
		if (acc.valid && permit && acc.write && !isKey)
			mem[memIdx] <= acc.wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			keyByte_reg[0] <= SMK_RST_UNSEAL0[15:8];
			keyByte_reg[1] <= SMK_RST_UNSEAL0[7:0];
			keyByte_reg[2] <= SMK_RST_UNSEAL1[15:8];
			keyByte_reg[3] <= SMK_RST_UNSEAL1[7:0];
			keyByte_reg[4] <= SMK_RST_FULL0[15:8];
			keyByte_reg[5] <= SMK_RST_FULL0[7:0];
			keyByte_reg[6] <= SMK_RST_FULL1[15:8];
			keyByte_reg[7] <= SMK_RST_FULL1[7:0];
			rdata_reg <= 8'h00;
			denied_reg <= 1'b0;
		end else begin
			// keys writable in full access only
			if (acc.valid && permit && acc.write && isKey)
				keyByte_reg[acc.offset[2:0]] <= acc.wdata;
			if (acc.valid && !acc.write && permit)
				rdata_reg <= isKey ? keyByte_reg[acc.offset[2:0]] : mem[memIdx];
			denied_reg <= acc.valid && !permit;
		end
	end
endmodule

/* File: verification/smk_security_asserts.sv */
// checker for the security-level controller
`timescale 1ns/100ps
module smk_security_asserts import smk_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// requests
	input wire logic classSelWr,
	input wire logic blockSelWr,
	input wire logic accValid,
	input wire logic accWrite,
	input wire logic [7:0] accOffset,
	// results
	input wire logic accDenied,
	input wire logic sealedFlag,
	input wire logic full_access_flag,
	input wire logic [2:0] level,
	input wire logic [7:0] class_select,
	input wire logic [7:0] block_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic sld = level == SMK_SEALED;
	wire logic keyWr = accValid && accWrite && class_select == SMK_CLASS_SECURITY;
	wire logic keyOfs = accOffset < 8'h08 && block_select[2:0] == 3'h0;
	lvl_onehot_a: assert property ($onehot(level)) else $error("level");
	seal_flag_a: assert property (sealedFlag == sld) else $error("sealed flag");
	full_flag_a: assert property (full_access_flag == (level != SMK_FULL))
		else $error("full flag");
	no_skip_a: assert property (sld |=> level != SMK_FULL) else $error("skip");
	class_hold_a: assert property (sld && classSelWr |=> $stable(class_select))
		else $error("class moved");
	block_hold_a: assert property (sld && blockSelWr |=> $stable(block_select))
		else $error("block moved");
	seal_write_a: assert property (sld && accValid && accWrite |=> accDenied)
		else $error("sealed write");
	key_guard_a: assert property (level != SMK_FULL && keyWr && keyOfs |=> accDenied)
		else $error("key write");
	deny_cause_a: assert property (accDenied |-> $past(accValid)) else $error("deny");
	cover property (level == SMK_UNSEALED);
	cover property (level == SMK_FULL);
	cover property (accDenied);
endmodule
bind smk_security smk_security_asserts chk (.ref_clk, .rst_b, .classSelWr, .blockSelWr, .accValid,
	.accWrite, .accOffset, .accDenied, .sealedFlag, .full_access_flag, .level,
	.class_select, .block_select);

/* File: verification/smk_host_model.sv */
// host that writes key words to the control port
`timescale 1ns/100ps
module smk_host_model import smk_pkg::*; (
	// clock
	input wire logic ref_clk,
	// control port
	output smk_ctl_s ctl
);
	initial ctl = '{1'b0, 16'hFFFF};
	// commit checksum from the low byte of the data sum
	function automatic logic [7:0] blockChecksum(input logic [7:0] sumLow);
		return 8'hFF - sumLow;
	endfunction
	task automatic sendPair(input logic [15:0] a, b);
		@(posedge ref_clk);
		#1 ctl = '{1'b1, a};
		@(posedge ref_clk);
		#1 ctl = '{1'b1, b};
		@(posedge ref_clk);
		// idle data is inverted so stale words never look valid
		#1 ctl = '{1'b0, ~b};
	endtask
endmodule

/* File: verification/test_smk_security.sv */
// bench for the security-level controller
`timescale 1ns/100ps
module test_smk_security import smk_pkg::*;;
	logic ref_clk = 0, rst_b = 0, sealCmd = 0, classSelWr = 0, blockSelWr = 0;
	logic accValid = 0, accWrite = 0, accDenied, sealedFlag, full_access_flag;
	logic [7:0] selData = 0, accOffset = 0, accWdata = 0, accRdata, class_select, block_select;
	logic [2:0] level;
	smk_ctl_s ctl;
	int n_fail = 0, total_checks = 0;
	always #10 ref_clk = ~ref_clk;
	smk_host_model host (.ref_clk, .ctl);
	smk_security uut (.ref_clk, .rst_b, .ctl, .sealCmd, .classSelWr, .blockSelWr,
		.selData, .accValid, .accWrite, .accOffset, .accWdata, .accRdata, .accDenied,
		.sealedFlag, .full_access_flag, .level, .class_select, .block_select);
	function automatic logic [15:0] sw(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic st(input logic [2:0] l, input logic s, f);
		chk(level === l && sealedFlag === s && full_access_flag === f, "status");
	endtask
	task automatic pair(input logic [15:0] a, b);
		host.sendPair(a, b);
		tick;
	endtask
	task automatic sel(input logic blk, input logic [7:0] c);
		{blockSelWr, classSelWr, selData} = {blk, !blk, c};
		tick;
		{blockSelWr, classSelWr} = 2'h0;
		tick;
	endtask
	task automatic acc(input logic w, input logic [7:0] o, d, input logic den);
		{accValid, accWrite, accOffset, accWdata} = {1'b1, w, o, d};
		tick;
		accValid = 0;
		chk(accDenied === den, "denial");
		tick;
	endtask
	task automatic t_sealed;
		st(SMK_SEALED, 1, 1);
		sel(1'b0, SMK_CLASS_SECURITY);
		chk(class_select === 8'h00, "select");
		sel(1'b1, 8'h02);
		chk(block_select === 8'h00, "block select");
		acc(1, 8'h00, 8'h55, 1);
		acc(0, 8'h00, 8'h00, 0);
		pair(SMK_RST_UNSEAL0, SMK_RST_UNSEAL1);
		pair(sw(SMK_RST_UNSEAL0), 16'h0000);
		pair(sw(SMK_RST_UNSEAL1), 16'h0000);
		pair(sw(SMK_RST_FULL0), sw(SMK_RST_FULL1));
		st(SMK_SEALED, 1, 1);
		$display("sealed test done");
	endtask
	task automatic t_unseal;
		pair(sw(SMK_RST_UNSEAL0), sw(SMK_RST_UNSEAL1));
		st(SMK_UNSEALED, 0, 1);
		sel(1'b0, SMK_CLASS_SECURITY);
		acc(1, SMK_OFS_UNSEAL0, 8'hAB, 1);
		sel(1'b0, 8'h50);
		acc(1, 8'h10, 8'hC3, 0);
		acc(0, 8'h10, 8'h00, 0);
		chk(accRdata === 8'hC3, "readback");
		sel(1'b1, 8'h01);
		chk(block_select === 8'h01, "block set");
		acc(1, 8'h10, 8'h5A, 0);
		sel(1'b1, 8'h00);
		acc(0, 8'h30, 8'h00, 0);
		chk(accRdata === 8'h5A, "block offset");
		// low byte of C3 plus 5A is 1D
		chk(host.blockChecksum(8'h1D) === 8'hE2, "checksum");
		$display("unseal test done");
	endtask
	task automatic t_full;
		pair(sw(SMK_RST_FULL0), sw(SMK_RST_FULL1));
		st(SMK_FULL, 0, 0);
		sel(1'b0, SMK_CLASS_SECURITY);
		acc(1, SMK_OFS_UNSEAL0, 8'hAB, 0);
		acc(0, SMK_OFS_UNSEAL0 + 8'h01, 8'h00, 0);
		chk(accRdata === SMK_RST_UNSEAL0[7:0], "key byte");
		sealCmd = 1;
		tick;
		sealCmd = 0;
		pair(sw(SMK_RST_UNSEAL0), sw(SMK_RST_UNSEAL1));
		st(SMK_SEALED, 1, 1);
		pair(sw(16'hAB34), sw(SMK_RST_UNSEAL1));
		st(SMK_UNSEALED, 0, 1);
		$display("full test done");
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 rst_b = 1;
		t_sealed;
		t_unseal;
		t_full;
		finish_test;
	end
	initial begin
		#1000000;
		chk(1'b0, "timeout");
		finish_test;
	end
endmodule
